/* File: csf_status_relays.sv */
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
// Operation
// RULE_01 - keep per-module I/O error bits
// RULE_02 - expose sixteen-bit system error code
// RULE_03 - reflect each fuse blown state
// RULE_04 - drive eight free-running cycle clock bits
// RULE_05 - each clock bit toggles at fixed period
// RULE_06 - set operation error flag on error
// RULE_07 - latched operation error copy stays set
// RULE_08 - zero flag when result equals zero
// RULE_09 - carry flag on carry out
// RULE_10 - all-outputs-off flag on that instruction
// RULE_11 - shared memory access error flag
// RULE_12 - compare sets relational flags from operands
// RULE_13 - compare updates all flags together
module csf_status_relays import csf_pkg::*; #(
   parameter int TICK_CYCLES = BASE_TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic exec_valid,
   input wire logic exec_op_error,
   input wire logic [OPND_W-1:0] exec_result,
   input wire logic exec_carry,
   input wire logic alloff_exec,
   input wire logic alloff_release,
   input wire logic shm_access,
   input wire logic shm_fail,
   input wire logic cmp_valid,
   input wire logic [OPND_W-1:0] cmp_src_a,
   input wire logic [OPND_W-1:0] cmp_src_b,
   input wire logic [IO_ERR_W-1:0] io_fault,
   input wire logic [ERRCODE_W-1:0] sys_error_code,
   input wire logic [FUSE_W-1:0] fuse_blown,
   output logic irq,
   output logic [NUM_CCLK-1:0] cycle_clk
);
   localparam logic [TICK_CW-1:0] TICK_LAST = TICK_CW'(TICK_CYCLES - 1);

   logic [IO_ERR_W-1:0] io_err_reg;
   logic [ERRCODE_W-1:0] errcode_reg;
   logic [FUSE_W-1:0] fuse_reg;
   logic op_err_reg;
   logic zero_reg;
   logic carry_reg;
   logic all_off_reg;
   logic shm_err_reg;
   logic op_latch_reg;
   logic [TICK_CW-1:0] tick_cnt_reg;
   logic tick_reg;
   logic [INT_W-1:0] int_status_reg;
   logic [INT_W-1:0] int_enable_reg;
   logic [INT_W-1:0] int_event;
   logic [INT_W-1:0] int_clear;
   logic [EXF_W-1:0] exec_flags;
   logic [DATA_W-1:0] rdata_next;
   logic addr_hit;
   logic setup;
   logic wr_en;
   logic clr_latch;
   logic op_err_event;
   logic irq_cond;
   logic [INT_W-1:0] wdata_int;

   csf_cmp_if cmp_bus ();

   // =====================================================
   // base tick
   // one 10 ms enable feeds every cycle clock, so all bits stay in phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else if (tick_cnt_reg == TICK_LAST) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   // =====================================================
   // cycle clocks
   for (genvar i = 0; i < NUM_CCLK; i++) begin : g_cclk
      csf_cycle_clock #(
         .HALF_TICKS(CCLK_PERIOD_MS[i] / (2 * BASE_TICK_MS))
      ) u_cclk (
         .pclk(pclk),
         .presetn(presetn),
         .tick(tick_reg),
         .clk_bit(cycle_clk[i]) // [RULE_04]
      );
   end

   // =====================================================
   // compare unit
   assign cmp_bus.valid = cmp_valid;
   assign cmp_bus.src_a = cmp_src_a;
   assign cmp_bus.src_b = cmp_src_b;

   csf_compare u_cmp (
      .pclk(pclk),
      .presetn(presetn),
      .cmp(cmp_bus.unit)
   );

   // =====================================================
   // module and system status mirrors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_err_reg <= RST_WORD;
         errcode_reg <= RST_ERRCODE;
         fuse_reg <= RST_WORD;
      end else begin
         io_err_reg <= io_fault; // [RULE_01]
         errcode_reg <= sys_error_code; // [RULE_02]
         fuse_reg <= fuse_blown; // [RULE_03]
      end
   end

   // =====================================================
   // instruction result flags
   assign op_err_event = exec_valid && exec_op_error;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_err_reg <= 1'b0;
         zero_reg <= 1'b0;
         carry_reg <= 1'b0;
      end else if (exec_valid) begin
         op_err_reg <= exec_op_error; // [RULE_06]
         zero_reg <= (exec_result == '0); // [RULE_08]
         carry_reg <= exec_carry; // [RULE_09]
      end
   end

   // set beats a same-cycle software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_latch_reg <= 1'b0;
      end else if (op_err_event) begin
         op_latch_reg <= 1'b1; // [RULE_07]
      end else if (clr_latch) begin
         op_latch_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         all_off_reg <= 1'b0;
      end else if (alloff_exec) begin
         all_off_reg <= 1'b1; // [RULE_10]
      end else if (alloff_release) begin
         all_off_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shm_err_reg <= 1'b0;
      end else if (shm_access) begin
         shm_err_reg <= shm_fail; // [RULE_11]
      end
   end

   always_comb begin
      exec_flags = '0;
      exec_flags[EXF_OP_ERR] = op_err_reg;
      exec_flags[EXF_ZERO] = zero_reg;
      exec_flags[EXF_CARRY] = carry_reg;
      exec_flags[EXF_ALL_OFF] = all_off_reg;
      exec_flags[EXF_SHM_ERR] = shm_err_reg;
      exec_flags[EXF_OP_LATCH] = op_latch_reg;
   end

   // =====================================================
   // interrupts
   always_comb begin
      int_event = '0;
      int_event[INT_OP_ERR] = op_err_event;
      int_event[INT_SHM_ERR] = shm_access && shm_fail;
      int_event[INT_ALL_OFF] = alloff_exec;
      int_event[INT_IO_ERR] = |(io_fault & ~io_err_reg);
      int_event[INT_FUSE] = |(fuse_blown & ~fuse_reg);
      int_event[INT_SYS_ERR] = (sys_error_code != errcode_reg)
         && (sys_error_code != '0);
   end

   assign wdata_int = pwdata[INT_W-1:0];
   assign int_clear = (wr_en && paddr == OFS_INT_CLEAR) ? wdata_int : '0;
   assign irq_cond = |(int_status_reg & int_enable_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_reg <= RST_INT;
      end else begin
         int_status_reg <= (int_status_reg & ~int_clear) | int_event;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_enable_reg <= RST_INT;
      end else if (wr_en && paddr == OFS_INT_ENABLE) begin
         int_enable_reg <= wdata_int;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_cond;
      end
   end

   // =====================================================
   // apb slave
   // answers in the first access cycle, no wait states
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite;
   assign clr_latch = wr_en && (paddr == OFS_CONTROL)
      && pwdata[CTRL_CLR_LATCH];

   always_comb begin
      addr_hit = 1'b1;
      rdata_next = RST_WORD;
      case (paddr)
         OFS_IO_ERR: rdata_next = io_err_reg;
         OFS_ERRCODE: rdata_next[ERRCODE_W-1:0] = errcode_reg;
         OFS_FUSE: rdata_next = fuse_reg;
         OFS_CYCCLK: rdata_next[NUM_CCLK-1:0] = cycle_clk;
         OFS_EXEC_FLAGS: rdata_next[EXF_W-1:0] = exec_flags;
         OFS_CMP_FLAGS: rdata_next[CMP_W-1:0] = cmp_bus.flags;
         OFS_CONTROL: rdata_next = RST_WORD;
         OFS_INT_STATUS: rdata_next[INT_W-1:0] = int_status_reg;
         OFS_INT_ENABLE: rdata_next[INT_W-1:0] = int_enable_reg;
         OFS_INT_CLEAR: rdata_next = RST_WORD;
         default: addr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && !addr_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= RST_WORD;
      end else if (setup && !pwrite) begin
         prdata <= rdata_next;
      end
   end

   // =====================================================
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_enable_write;
      psel && penable && pready && pwrite && paddr == OFS_INT_ENABLE;
   endsequence

   AST_APB_READY: assert property (s_setup |=> pready)
      else $error("no ready in access cycle");
   AST_APB_ENABLE_WR: assert property (
      s_setup ##1 s_enable_write |=> int_enable_reg == $past(wdata_int))
      else $error("enable register write lost");
   AST_IO_ERR: assert property ( // [RULE_01]
      ##1 io_err_reg == $past(io_fault))
      else $error("io error bits do not follow modules");
   AST_ERRCODE: assert property ( // [RULE_02]
      ##1 errcode_reg == $past(sys_error_code))
      else $error("error code not mirrored");
   AST_FUSE: assert property ( // [RULE_03]
      ##1 fuse_reg == $past(fuse_blown))
      else $error("fuse state not mirrored");
   AST_OP_ERR: assert property ( // [RULE_06]
      exec_valid |=> op_err_reg == $past(exec_op_error))
      else $error("operation error flag wrong");
   AST_OP_LATCH: assert property ( // [RULE_07]
      op_err_event ##1 !clr_latch [*3] |=> op_latch_reg)
      else $error("latched operation error dropped");
   AST_ZERO: assert property ( // [RULE_08]
      exec_valid |=> zero_reg == ($past(exec_result) == '0))
      else $error("zero flag wrong");
   AST_CARRY: assert property ( // [RULE_09]
      exec_valid |=> carry_reg == $past(exec_carry))
      else $error("carry flag wrong");
   AST_ALL_OFF: assert property ( // [RULE_10]
      alloff_exec |=> all_off_reg)
      else $error("all outputs off flag not set");
   AST_SHM: assert property ( // [RULE_11]
      shm_access |=> shm_err_reg == $past(shm_fail))
      else $error("shared memory error flag wrong");
   AST_IRQ: assert property (##1 irq == $past(irq_cond))
      else $error("interrupt output wrong");
   AST_TICK: assert property (tick_reg |-> ##1 !tick_reg)
      else $error("base tick longer than one cycle");
   AST_TICK_WRAP: assert property (tick_reg |-> tick_cnt_reg == '0)
      else $error("base tick not aligned to counter wrap");
   AST_APB_IDLE: assert property (
      !(psel && !penable) |=> !pready && !pslverr)
      else $error("ready or error outside access cycle");
   AST_APB_ERR: assert property (psel && !penable
      && (paddr > OFS_INT_CLEAR || paddr[1:0] != 2'b00) |=> pslverr)
      else $error("unmapped address not flagged");
   AST_APB_OK: assert property (psel && !penable
      && paddr <= OFS_INT_CLEAR && paddr[1:0] == 2'b00 |=> !pslverr)
      else $error("mapped address flagged as error");
   AST_RD_CMP: assert property ( // [RULE_12]
      psel && !penable && !pwrite && paddr == OFS_CMP_FLAGS
      |=> prdata == DATA_W'($past(cmp_bus.flags)))
      else $error("compare flags not returned on read");
   AST_LATCH_CLR: assert property ( // [RULE_07]
      clr_latch && !op_err_event |=> !op_latch_reg)
      else $error("latched operation error not cleared");
   AST_ALL_OFF_CLR: assert property ( // [RULE_10]
      alloff_release && !alloff_exec |=> !all_off_reg)
      else $error("all outputs off flag not released");
   AST_INT_SET: assert property ( // [RULE_06]
      op_err_event |=> int_status_reg[INT_OP_ERR])
      else $error("operation error status not set");
   AST_INT_CLR: assert property (
      int_clear[INT_OP_ERR] && !op_err_event |=> !int_status_reg[INT_OP_ERR])
      else $error("operation error status not cleared");
   AST_SHM_INT: assert property ( // [RULE_11]
      shm_access && shm_fail |=> int_status_reg[INT_SHM_ERR])
      else $error("shared memory status not set");
endmodule

/* File: csf_pkg.sv */
package csf_pkg;
   // =====================================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_MS = 1000000;
   localparam int BASE_TICK_MS = 10;
   localparam int BASE_TICK_CYCLES = BASE_TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int TICK_CW = 20;
   localparam int NUM_CCLK = 8;
   localparam int CCLK_PERIOD_MS [NUM_CCLK] =
      '{20, 100, 200, 1000, 2000, 10000, 20000, 60000};
   localparam int CCLK_CNT_W = 12;
   // =====================================================
   // widths
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;
   localparam int OPND_W = 16;
   localparam int IO_ERR_W = 32;
   localparam int ERRCODE_W = 16;
   localparam int FUSE_W = 32;
   localparam int EXF_W = 6;
   localparam int CMP_W = 6;
   localparam int INT_W = 6;
   // =====================================================
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_IO_ERR = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_ERRCODE = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_FUSE = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_CYCCLK = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_EXEC_FLAGS = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_CMP_FLAGS = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h01C;
   localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 12'h020;
   localparam logic [ADDR_W-1:0] OFS_INT_CLEAR = 12'h024;
   // =====================================================
   // field positions
   localparam int EXF_OP_ERR = 0;
   localparam int EXF_ZERO = 1;
   localparam int EXF_CARRY = 2;
   localparam int EXF_ALL_OFF = 3;
   localparam int EXF_SHM_ERR = 4;
   localparam int EXF_OP_LATCH = 5;
   localparam int CMP_LT = 0;
   localparam int CMP_LTE = 1;
   localparam int CMP_EQ = 2;
   localparam int CMP_GT = 3;
   localparam int CMP_GTE = 4;
   localparam int CMP_NEQ = 5;
   localparam int INT_OP_ERR = 0;
   localparam int INT_SHM_ERR = 1;
   localparam int INT_ALL_OFF = 2;
   localparam int INT_IO_ERR = 3;
   localparam int INT_FUSE = 4;
   localparam int INT_SYS_ERR = 5;
   localparam int CTRL_CLR_LATCH = 0;
   // =====================================================
   // reset values
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
   localparam logic [ERRCODE_W-1:0] RST_ERRCODE = 16'h0000;
   localparam logic [CMP_W-1:0] RST_CMP = 6'h00;
   localparam logic [INT_W-1:0] RST_INT = 6'h00;
endpackage

/* File: csf_cmp_if.sv */
`timescale 1ns/1ps
interface csf_cmp_if;
   import csf_pkg::*;
   logic valid;
   logic [OPND_W-1:0] src_a;
   logic [OPND_W-1:0] src_b;
   logic [CMP_W-1:0] flags;
   modport exec (output valid, output src_a, output src_b, input flags);
   modport unit (input valid, input src_a, input src_b, output flags);
endinterface

/* File: csf_cycle_clock.sv */
`timescale 1ns/1ps
module csf_cycle_clock import csf_pkg::*; #(
   parameter int HALF_TICKS = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   output logic clk_bit
);
   localparam logic [CCLK_CNT_W-1:0] LAST = CCLK_CNT_W'(HALF_TICKS - 1);
   logic [CCLK_CNT_W-1:0] cnt_reg;
   logic flip;

   assign flip = tick && (cnt_reg == LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
         clk_bit <= 1'b0;
      end else if (flip) begin
         cnt_reg <= '0;
         clk_bit <= ~clk_bit; // [RULE_05]
      end else if (tick) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // =====================================================
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_CCLK_FLIP: assert property ( // [RULE_05]
      flip |=> clk_bit != $past(clk_bit))
      else $error("cycle clock did not toggle");
   AST_CCLK_STEADY: assert property ( // [RULE_04]
      !flip |=> $stable(clk_bit))
      else $error("cycle clock moved between half periods");
   AST_CCLK_BOUND: assert property (cnt_reg <= LAST)
      else $error("cycle clock counter out of range");
endmodule

/* File: csf_compare.sv */
`timescale 1ns/1ps
module csf_compare import csf_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   csf_cmp_if.unit cmp
);
   logic [CMP_W-1:0] flags_reg;
   logic [CMP_W-1:0] flags_next;
   logic signed [OPND_W-1:0] a_s;
   logic signed [OPND_W-1:0] b_s;

   always_comb begin
      a_s = signed'(cmp.src_a);
      b_s = signed'(cmp.src_b);
      flags_next = RST_CMP;
      flags_next[CMP_LT] = a_s < b_s; // [RULE_12]
      flags_next[CMP_LTE] = a_s <= b_s;
      flags_next[CMP_EQ] = a_s == b_s;
      flags_next[CMP_GT] = a_s > b_s;
      flags_next[CMP_GTE] = a_s >= b_s;
      flags_next[CMP_NEQ] = a_s != b_s;
   end

   // whole vector loaded at once, false relations drop to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= RST_CMP;
      end else if (cmp.valid) begin
         flags_reg <= flags_next; // [RULE_13]
      end
   end

   assign cmp.flags = flags_reg;

   // =====================================================
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_CMP_LT: assert property ( // [RULE_12]
      cmp.valid |=> flags_reg[CMP_LT] == ($past(a_s) < $past(b_s)))
      else $error("less-than flag wrong");
   AST_CMP_NEQ: assert property ( // [RULE_12]
      cmp.valid |=> flags_reg[CMP_NEQ] == ($past(a_s) != $past(b_s)))
      else $error("not-equal flag wrong");
   AST_CMP_SET: assert property ( // [RULE_13]
      cmp.valid |=> (flags_reg[CMP_LT] ^ flags_reg[CMP_GTE])
         && (flags_reg[CMP_GT] ^ flags_reg[CMP_LTE]))
      else $error("compare flags inconsistent");
   AST_CMP_HOLD: assert property (!cmp.valid |=> $stable(flags_reg))
      else $error("compare flags changed without compare");
endmodule

/* File: csf_status_relays_tb.sv */
`timescale 1ns/1ps
module tb;
   import csf_pkg::*;
   // ==========================================
   // signals
   localparam int TICKS = 4;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic exec_valid = 1'b0;
   logic exec_op_error = 1'b0;
   logic [OPND_W-1:0] exec_result = '0;
   logic exec_carry = 1'b0;
   logic alloff_exec = 1'b0;
   logic alloff_release = 1'b0;
   logic shm_access = 1'b0;
   logic shm_fail = 1'b0;
   logic cmp_valid = 1'b0;
   logic [OPND_W-1:0] cmp_src_a = '0;
   logic [OPND_W-1:0] cmp_src_b = '0;
   logic [IO_ERR_W-1:0] io_fault = '0;
   logic [ERRCODE_W-1:0] sys_error_code = '0;
   logic [FUSE_W-1:0] fuse_blown = '0;
   logic irq;
   logic [NUM_CCLK-1:0] cycle_clk;
   logic [33:0] exp_q [$];
   logic [33:0] exp_e;
   logic [5:0] exf = '0;
   int bad_count = 0;
   int comparisons = 0;

   csf_status_relays #(.TICK_CYCLES(TICKS)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .exec_valid(exec_valid),
      .exec_op_error(exec_op_error), .exec_result(exec_result),
      .exec_carry(exec_carry), .alloff_exec(alloff_exec),
      .alloff_release(alloff_release), .shm_access(shm_access),
      .shm_fail(shm_fail), .cmp_valid(cmp_valid), .cmp_src_a(cmp_src_a),
      .cmp_src_b(cmp_src_b), .io_fault(io_fault),
      .sys_error_code(sys_error_code), .fuse_blown(fuse_blown),
      .irq(irq), .cycle_clk(cycle_clk));

   always #5 pclk = ~pclk;

   // ==========================================
   // checking and verdict
   task automatic check(input logic [DATA_W-1:0] seen,
      input logic [DATA_W-1:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("compared %0d, mismatched %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // monitor: each completed transfer consumes the oldest note
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(32'h0, 32'h1);
         end else begin
            exp_e = exp_q.pop_front();
            check({31'h0, pslverr}, {31'h0, exp_e[32]});
            if (!exp_e[33]) check(prdata, exp_e[31:0]);
         end
      end
   end

   // ==========================================
   // drivers
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] e,
      input logic err);
      int n;
      exp_q.push_back({wr, err, e});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
         bad_count++;
         print_verdict();
      end
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      apb(1'b0, a, 32'h0, e, 1'b0);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask

   task automatic exec_op(input logic e, input logic [OPND_W-1:0] r,
      input logic c);
      @(posedge pclk);
      exec_valid <= 1'b1;
      exec_op_error <= e;
      exec_result <= r;
      exec_carry <= c;
      @(posedge pclk);
      exec_valid <= 1'b0;
      exf[EXF_OP_ERR] = e;
      exf[EXF_ZERO] = (r == 16'h0000);
      exf[EXF_CARRY] = c;
      if (e) exf[EXF_OP_LATCH] = 1'b1;
   endtask

   // k: 0 all-off, 1 release, 2 shared access ok, 3 shared access fails
   task automatic evt(input int k);
      @(posedge pclk);
      alloff_exec <= (k == 0);
      alloff_release <= (k == 1);
      shm_access <= (k >= 2);
      shm_fail <= (k == 3);
      @(posedge pclk);
      alloff_exec <= 1'b0;
      alloff_release <= 1'b0;
      shm_access <= 1'b0;
      if (k < 2) exf[EXF_ALL_OFF] = (k == 0);
      else exf[EXF_SHM_ERR] = (k == 3);
   endtask

   task automatic cmp(input logic [OPND_W-1:0] a, input logic [OPND_W-1:0] b);
      logic [DATA_W-1:0] f;
      f = '0;
      f[CMP_LT] = $signed(a) < $signed(b);
      f[CMP_LTE] = $signed(a) <= $signed(b);
      f[CMP_EQ] = a == b;
      f[CMP_GT] = $signed(a) > $signed(b);
      f[CMP_GTE] = $signed(a) >= $signed(b);
      f[CMP_NEQ] = a != b;
      @(posedge pclk);
      cmp_valid <= 1'b1;
      cmp_src_a <= a;
      cmp_src_b <= b;
      @(posedge pclk);
      cmp_valid <= 1'b0;
      rd(OFS_CMP_FLAGS, f);
   endtask

   // period in pclk cycles between two rising edges of one clock bit
   task automatic measure(input int i);
      int n;
      int r1;
      int per;
      logic prev;
      per = 2 * TICKS * (CCLK_PERIOD_MS[i] / (2 * BASE_TICK_MS));
      r1 = -1;
      prev = cycle_clk[i];
      for (n = 0; n < 3 * per; n++) begin
         @(posedge pclk);
         #1;
         if (cycle_clk[i] === 1'b1 && prev === 1'b0) begin
            if (r1 >= 0) break;
            r1 = n;
         end
         prev = cycle_clk[i];
      end
      check(32'(n - r1), 32'(per));
   endtask

   // ==========================================
   // main sequence
   initial begin
      logic [31:0] v1;
      logic [31:0] v2;
      logic [15:0] v3;
      void'($urandom(32'h15c6c56b));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      check({24'h0, cycle_clk}, 32'h0);
      for (int a = 0; a <= 36; a += 4) rd(ADDR_W'(a), 32'h0);
      apb(1'b0, 12'h028, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'hFFC, 32'hFFFF_FFFF, 32'h0, 1'b1);
      $display("test reset done");

      for (int j = 0; j < 3; j++) begin
         v1 = (j == 2) ? 32'h0 : $urandom();
         v2 = (j == 2) ? 32'h0 : $urandom();
         v3 = (j == 2) ? 16'h0 : 16'($urandom());
         @(posedge pclk);
         io_fault <= v1;
         fuse_blown <= v2;
         sys_error_code <= v3;
         rd(OFS_IO_ERR, v1);
         wr(OFS_IO_ERR, ~v1);
         rd(OFS_IO_ERR, v1);
         rd(OFS_ERRCODE, {16'h0, v3});
         rd(OFS_FUSE, v2);
      end
      $display("test mirrors done");

      exec_op(1'b0, 16'h0000, 1'b0);
      rd(OFS_EXEC_FLAGS, {26'h0, exf});
      exec_op(1'b1, 16'hFFFF, 1'b1);
      rd(OFS_EXEC_FLAGS, {26'h0, exf});
      for (int j = 0; j < 4; j++) begin
         exec_op(1'b0, 16'($urandom_range(1, 65535)), 1'($urandom()));
         rd(OFS_EXEC_FLAGS, {26'h0, exf});
      end
      wr(OFS_CONTROL, 32'h1);
      exf[EXF_OP_LATCH] = 1'b0;
      rd(OFS_EXEC_FLAGS, {26'h0, exf});
      for (int k = 0; k < 4; k++) begin
         evt(k);
         rd(OFS_EXEC_FLAGS, {26'h0, exf});
      end
      $display("test execution flags done");

      cmp(16'h0000, 16'h0000);
      cmp(16'h8000, 16'h7FFF);
      cmp(16'h7FFF, 16'h8000);
      cmp(16'hFFFF, 16'h0000);
      for (int j = 0; j < 12; j++) cmp(16'($urandom()), 16'($urandom()));
      $display("test compare done");

      wr(OFS_INT_CLEAR, 32'h3F);
      rd(OFS_INT_STATUS, 32'h0);
      wr(OFS_INT_ENABLE, 32'h1 << INT_OP_ERR);
      rd(OFS_INT_ENABLE, 32'h1 << INT_OP_ERR);
      exec_op(1'b1, 16'h0001, 1'b0);
      repeat (2) @(posedge pclk);
      #1;
      check({31'h0, irq}, 32'h1);
      rd(OFS_INT_STATUS, 32'h1 << INT_OP_ERR);
      wr(OFS_INT_CLEAR, 32'h1 << INT_OP_ERR);
      repeat (2) @(posedge pclk);
      #1;
      check({31'h0, irq}, 32'h0);
      wr(OFS_INT_ENABLE, 32'h0);
      evt(3);
      evt(0);
      repeat (2) @(posedge pclk);
      #1;
      check({31'h0, irq}, 32'h0);
      rd(OFS_INT_STATUS, (32'h1 << INT_SHM_ERR) | (32'h1 << INT_ALL_OFF));
      $display("test interrupts done");

      for (int i = 0; i < NUM_CCLK; i++) measure(i);
      $display("test cycle clocks done");
      repeat (2) @(posedge pclk);
      print_verdict();
   end
endmodule
